// *** verilog/dcf_defines.svh ***
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH

// ----------------------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------------------
`define DCF_DATA_W      9
`define DCF_OFS_W       15
`define DCF_LO_W        9
`define DCF_HI_PAD      3'h0
`define DCF_SEL_W       2

// ----------------------------------------------------------------------------
// Offset word selection order
// ----------------------------------------------------------------------------
`define DCF_SEL_EMPTY_LO 2'h0
`define DCF_SEL_EMPTY_HI 2'h1
`define DCF_SEL_FULL_LO  2'h2
`define DCF_SEL_FULL_HI  2'h3
`define DCF_SEL_STEP     2'h1

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define DCF_OFS_DEF_SHORT 15'h007F
`define DCF_OFS_DEF_LONG  15'h03FF
`define DCF_RETX_HOLD     2'h2
`define DCF_RETX_STEP     2'h1
`define DCF_HOLD_IDLE     2'h0

`endif

// *** verilog/dcf_pkg.sv ***
`include "dcf_defines.svh"

package dcf_pkg;

    typedef logic [`DCF_DATA_W-1:0] dcf_word_t;

    typedef struct packed {
        logic [`DCF_OFS_W-1:0] full;
        logic [`DCF_OFS_W-1:0] empty;
    } dcf_offsets_t;

    typedef struct packed {
        logic fr;
        logic pr;
        logic ofs_sel;
        logic oe_n;
        logic fwft;
        logic ofs_tgl;
    } dcf_rd_ctl_t;

    typedef struct packed {
        logic fr;
        logic pr;
    } dcf_wr_ctl_t;

endpackage

// *** verilog/dcf_fifo.sv ***
// What this block does
// (R01) Nine-bit words in on data_in, out on data_out
// (R02) Full reset zeroes pointers and output register
// (R03) Full reset samples pin for timing mode
// (R04) Full reset picks default offset 127 or 1023
// (R05) Partial reset zeroes pointers, keeps mode and offsets
// (R06) Replay request resets read pointer only
// (R07) Replay forces not-ready flag until data returns
// (R08) After full reset, mode pin is serial input
// (R09) Write enable stores word or parallel offset
// (R10) Serial load enable shifts one offset bit
// (R11) Read enable delivers next word or offset
// (R12) Output enable sets data_out_oe_n; data_out is always driven
// (R13) Offset select redirects reads and writes
// (R14) Standard mode: shared output is full flag
// (R15) Fall-through mode: shared output is input ready
// (R16) Standard mode: shared output is empty flag
// (R17) Fall-through mode: shared output is output ready
// (R18) Almost-full low above capacity minus full offset
// (R19) Almost-empty low below empty offset
// (R20) Half-full flag compares count to half capacity
// (R21) Short default means parallel, long means serial
// (R22) Capacity 16384 or 32768 nine-bit words
// (R23) Fall-through first word appears after three edges
// (R24) Flags per domain, Gray pointers cross domains
// (R25) Writes when full, reads when empty ignored
`timescale 1ns/1ps
`include "dcf_defines.svh"

module dcf_fifo #(
    parameter int DEPTH = 16384
) (
    input  wire logic             core_clk,               // Write clock
    input  wire logic             nrst,                   // Async reset, active low
    input  wire logic             rd_clk,                 // Read clock
    input  wire logic             full_reset,             // Full reset, async pin
    input  wire logic             partial_reset,          // Partial reset, async pin
    input  wire logic             fall_through_mode,      // Mode strap / serial input
    input  wire logic             offset_access_select,   // Offset access / default pick
    input  wire logic             write_enable,           // Write request
    input  wire logic             serial_load_enable,     // Serial offset shift
    input  wire dcf_pkg::dcf_word_t data_in,              // Write data
    input  wire logic             read_enable,            // Read request
    input  wire logic             replay_request,         // Retransmit request
    input  wire logic             output_drive_enable_n,  // Output drive, async pin
    output logic                  full_input_ready_n,     // Full flag / input ready
    output logic                  empty_output_ready_n,   // Empty flag / output ready
    output logic                  almost_full_flag_n,     // Almost full
    output logic                  almost_empty_flag_n,    // Almost empty
    output logic                  half_full_flag_n,       // Half full
    output dcf_pkg::dcf_word_t    data_out,               // Read data
    output logic                  data_out_oe_n           // Output enable, two read-clock stages behind the pin
);
    import dcf_pkg::*;

    localparam int AW = $clog2(DEPTH);   // (R22)
    localparam int PW = AW + 1;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [PW-1:0] bin2gray(logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] gray2bin(logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i+1]);
        end
        return b;
    endfunction

    function automatic dcf_word_t ofs_word(dcf_offsets_t o, logic [`DCF_SEL_W-1:0] sel);
        case (sel)
            `DCF_SEL_EMPTY_LO: return o.empty[`DCF_LO_W-1:0];
            `DCF_SEL_EMPTY_HI: return {`DCF_HI_PAD, o.empty[`DCF_OFS_W-1:`DCF_LO_W]};
            `DCF_SEL_FULL_LO:  return o.full[`DCF_LO_W-1:0];
            default:           return {`DCF_HI_PAD, o.full[`DCF_OFS_W-1:`DCF_LO_W]};
        endcase
    endfunction

    dcf_word_t mem [DEPTH];

    // ------------------------------------------------------------------------
    // Write domain
    // ------------------------------------------------------------------------
    dcf_wr_ctl_t         wctl1_q, wctl2_q;
    logic                fwft_q, serial_q, ofs_tgl_q, ofs_pend_q, ofs_chg;
    logic                ack1_q, ack2_q, rtgl_q;
    dcf_offsets_t        ofs_q, ofs_snap_q;
    logic [`DCF_SEL_W-1:0] wsel_q;
    logic [PW-1:0]       wbin_q, wbin_d, wgray_q, rg1_q, rg2_q, rsync_bin, wcnt_d, rgray_q;
    logic                wclr, wr_fire, par_load, ser_load;
    logic                full_q, afull_n_q, half_n_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wctl1_q <= '0;
            wctl2_q <= '0;
        end else begin
            wctl1_q <= '{fr: full_reset, pr: partial_reset};
            wctl2_q <= wctl1_q;
        end
    end

    assign wclr     = wctl2_q.fr | wctl2_q.pr;
    assign par_load = !wclr && offset_access_select && !serial_q && write_enable;
    assign ser_load = !wclr && offset_access_select && serial_q && serial_load_enable;
    assign wr_fire  = !wclr && write_enable && !offset_access_select && !full_q;  // (R25)
    assign ofs_chg  = wctl2_q.fr || ser_load || par_load;

    // Mode straps, caught on every edge while full reset is held
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fwft_q   <= 1'b0;
            serial_q <= 1'b0;
        end else if (wctl2_q.fr) begin
            fwft_q   <= fall_through_mode;      // (R03)
            serial_q <= offset_access_select;   // (R21)
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ofs_q <= '{full: `DCF_OFS_DEF_SHORT, empty: `DCF_OFS_DEF_SHORT};
        end else if (wctl2_q.fr) begin
            if (offset_access_select) begin   // (R04)
                ofs_q <= '{full: `DCF_OFS_DEF_LONG, empty: `DCF_OFS_DEF_LONG};
            end else begin
                ofs_q <= '{full: `DCF_OFS_DEF_SHORT, empty: `DCF_OFS_DEF_SHORT};
            end
        end else if (ser_load) begin
            ofs_q <= {fall_through_mode, ofs_q[2*`DCF_OFS_W-1:1]};   // (R08) (R10)
        end else if (par_load) begin   // (R09) (R13)
            case (wsel_q)
                `DCF_SEL_EMPTY_LO: ofs_q.empty[`DCF_LO_W-1:0] <= data_in;
                `DCF_SEL_EMPTY_HI: ofs_q.empty[`DCF_OFS_W-1:`DCF_LO_W] <=
                                       data_in[`DCF_OFS_W-`DCF_LO_W-1:0];
                `DCF_SEL_FULL_LO:  ofs_q.full[`DCF_LO_W-1:0] <= data_in;
                default:           ofs_q.full[`DCF_OFS_W-1:`DCF_LO_W] <=
                                       data_in[`DCF_OFS_W-`DCF_LO_W-1:0];
            endcase
        end
    end

    // Offsets cross as a held snapshot under a toggle handshake, so a burst
    // of changes faster than the read clock is neither lost nor torn
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ofs_tgl_q  <= 1'b0;
            ofs_pend_q <= 1'b0;
            ofs_snap_q <= '{full: `DCF_OFS_DEF_SHORT, empty: `DCF_OFS_DEF_SHORT};
            ack1_q     <= 1'b0;
            ack2_q     <= 1'b0;
            wsel_q     <= `DCF_SEL_EMPTY_LO;
        end else begin
            ack1_q     <= rtgl_q;
            ack2_q     <= ack1_q;
            ofs_pend_q <= ofs_chg || (ofs_pend_q && ack2_q != ofs_tgl_q);
            if (ofs_pend_q && ack2_q == ofs_tgl_q) begin
                ofs_snap_q <= ofs_q;
                ofs_tgl_q  <= !ofs_tgl_q;
            end
            if (wclr) begin
                wsel_q <= `DCF_SEL_EMPTY_LO;
            end else if (par_load) begin
                wsel_q <= wsel_q + `DCF_SEL_STEP;
            end
        end
    end

    assign wbin_d    = wclr ? '0 : (wr_fire ? wbin_q + PW'(1) : wbin_q);   // (R02) (R05)
    assign rsync_bin = gray2bin(rg2_q);
    assign wcnt_d    = wbin_d - rsync_bin;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wbin_q  <= '0;
            wgray_q <= '0;
            rg1_q   <= '0;
            rg2_q   <= '0;
        end else begin
            wbin_q  <= wbin_d;
            wgray_q <= bin2gray(wbin_q);   // (R24)
            rg1_q   <= rgray_q;
            rg2_q   <= rg1_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_fire) begin
            mem[wbin_q[AW-1:0]] <= data_in;   // (R09)
        end
    end

    // Write-side flags
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            full_q    <= 1'b0;
            afull_n_q <= 1'b1;
            half_n_q  <= 1'b1;
        end else if (wclr) begin
            full_q    <= 1'b0;
            afull_n_q <= 1'b1;
            half_n_q  <= 1'b1;
        end else begin
            full_q    <= (wcnt_d == PW'(DEPTH));                               // (R14) (R15)
            afull_n_q <= !(wcnt_d > (PW'(DEPTH) - PW'(ofs_q.full)));           // (R18)
            half_n_q  <= !(wcnt_d > PW'(DEPTH / 2));                           // (R20)
        end
    end

    assign full_input_ready_n = full_q;   // (R14) (R15)
    assign almost_full_flag_n = afull_n_q;
    assign half_full_flag_n   = half_n_q;

    // ------------------------------------------------------------------------
    // Read domain
    // ------------------------------------------------------------------------
    dcf_rd_ctl_t         rctl1_q, rctl2_q;
    dcf_offsets_t        rofs_q;
    logic [`DCF_SEL_W-1:0] rsel_q;
    logic [1:0]          hold_q, hold_d;
    logic [PW-1:0]       rbin_q, rbin_d, wg1_q, wg2_q, wsync_bin, rcnt_d;
    logic                rclr, rd_ofs, load, ov_q, ov_d, empty_now;
    logic                shared_n_q, aempty_n_q;
    dcf_word_t           dout_q;

    always_ff @(posedge rd_clk or negedge nrst) begin
        if (!nrst) begin
            rctl1_q <= '0;
            rctl2_q <= '0;
            wg1_q   <= '0;
            wg2_q   <= '0;
        end else begin
            rctl1_q <= '{fr: full_reset, pr: partial_reset, ofs_sel: offset_access_select,
                         oe_n: output_drive_enable_n, fwft: fwft_q, ofs_tgl: ofs_tgl_q};
            rctl2_q <= rctl1_q;
            wg1_q   <= wgray_q;   // (R24)
            wg2_q   <= wg1_q;
        end
    end

    // Offsets are copied only after the toggle settled, so the bus is stable
    always_ff @(posedge rd_clk or negedge nrst) begin
        if (!nrst) begin
            rtgl_q <= 1'b0;
            rofs_q <= '{full: `DCF_OFS_DEF_SHORT, empty: `DCF_OFS_DEF_SHORT};
        end else begin
            rtgl_q <= rctl2_q.ofs_tgl;
            if (rtgl_q != rctl2_q.ofs_tgl) begin
                rofs_q <= ofs_snap_q;
            end
        end
    end

    assign rclr      = rctl2_q.fr | rctl2_q.pr;
    assign wsync_bin = gray2bin(wg2_q);
    assign empty_now = (rbin_q == wsync_bin);
    assign rd_ofs    = !rclr && read_enable && rctl2_q.ofs_sel;   // (R11) (R13)

    always_comb begin
        load = 1'b0;
        if (!rclr && !replay_request && hold_q == `DCF_HOLD_IDLE && !empty_now) begin  // (R25)
            if (rctl2_q.fwft) begin
                load = !ov_q || (read_enable && !rctl2_q.ofs_sel);   // (R23)
            end else begin
                load = read_enable && !rctl2_q.ofs_sel;
            end
        end
    end

    always_comb begin
        rbin_d = rbin_q;
        ov_d   = ov_q;
        hold_d = (hold_q == `DCF_HOLD_IDLE) ? hold_q : hold_q - `DCF_RETX_STEP;
        if (rclr) begin
            rbin_d = '0;   // (R02) (R05)
            ov_d   = 1'b0;
            hold_d = `DCF_HOLD_IDLE;
        end else if (replay_request) begin
            rbin_d = '0;   // (R06)
            ov_d   = 1'b0;
            hold_d = `DCF_RETX_HOLD;   // (R07)
        end else if (load) begin
            rbin_d = rbin_q + PW'(1);
            ov_d   = 1'b1;
        end else if (rctl2_q.fwft && read_enable && !rctl2_q.ofs_sel) begin
            ov_d   = 1'b0;
        end
    end

    assign rcnt_d = wsync_bin - rbin_d;

    always_ff @(posedge rd_clk or negedge nrst) begin
        if (!nrst) begin
            rbin_q  <= '0;
            rgray_q <= '0;
            ov_q    <= 1'b0;
            hold_q  <= `DCF_HOLD_IDLE;
        end else begin
            rbin_q  <= rbin_d;
            rgray_q <= bin2gray(rbin_d);
            ov_q    <= ov_d;
            hold_q  <= hold_d;
        end
    end

    always_ff @(posedge rd_clk or negedge nrst) begin
        if (!nrst) begin
            dout_q <= '0;
            rsel_q <= `DCF_SEL_EMPTY_LO;
        end else if (rclr) begin
            dout_q <= '0;   // (R02) (R05)
            rsel_q <= `DCF_SEL_EMPTY_LO;
        end else if (rd_ofs) begin
            dout_q <= ofs_word(rofs_q, rsel_q);   // (R11)
            rsel_q <= rsel_q + `DCF_SEL_STEP;
        end else if (load) begin
            dout_q <= mem[rbin_q[AW-1:0]];   // (R01) (R11)
        end
    end

    // Shared empty / output-ready pin and almost-empty
    always_ff @(posedge rd_clk or negedge nrst) begin
        if (!nrst) begin
            shared_n_q <= 1'b0;
            aempty_n_q <= 1'b0;
        end else begin
            if (rctl2_q.fwft) begin
                shared_n_q <= !ov_d;   // (R17)
            end else begin
                shared_n_q <= (rbin_d != wsync_bin) && (hold_d == `DCF_HOLD_IDLE);   // (R16)
            end
            aempty_n_q <= !(rcnt_d < PW'(rofs_q.empty));   // (R19)
        end
    end

    assign empty_output_ready_n = shared_n_q;
    assign almost_empty_flag_n  = aempty_n_q;
    assign data_out             = dout_q;
    assign data_out_oe_n        = rctl2_q.oe_n;   // (R12)

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence replay_s;
        replay_request && !rclr;
    endsequence

    sequence full_write_s;
        full_q && write_enable && !offset_access_select;
    endsequence

    AST_FULL_RESET_PTRS: assert property (@(posedge core_clk) disable iff (!nrst) // (R02)
        wctl2_q.fr |=> (wbin_q == '0) ##1 (wgray_q == '0))
        else $error("write pointer not cleared by full reset");

    AST_FULL_DEFAULT: assert property (@(posedge core_clk) disable iff (!nrst) // (R04)
        wctl2_q.fr && offset_access_select |=>
            ofs_q.empty == `DCF_OFS_DEF_LONG && ofs_q.full == `DCF_OFS_DEF_LONG && serial_q)
        else $error("long default offset or serial method not taken");

    AST_PARTIAL_KEEPS: assert property (@(posedge core_clk) disable iff (!nrst) // (R05)
        wctl2_q.pr && !wctl2_q.fr |=>
            $stable(fwft_q) && $stable(serial_q) && $stable(ofs_q) && wbin_q == '0)
        else $error("partial reset disturbed settings");

    AST_FULL_NO_WRITE: assert property (@(posedge core_clk) disable iff (!nrst) // (R25)
        full_write_s |=> $stable(wbin_q))
        else $error("write accepted while full");

    AST_FULL_ONLY_BY_WRITE: assert property (@(posedge core_clk) disable iff (!nrst) // (R14)
        !full_q ##1 full_q |-> $past(wr_fire))
        else $error("full flag rose without a write");

    AST_REPLAY_PTR: assert property (@(posedge rd_clk) disable iff (!nrst) // (R06)
        replay_s |=> rbin_q == '0 && rgray_q == '0 && !ov_q)
        else $error("replay did not restart read pointer");

    AST_REPLAY_FLAG: assert property (@(posedge rd_clk) disable iff (!nrst) // (R07)
        replay_s |=> (rctl2_q.fwft ? shared_n_q : !shared_n_q)[*2])
        else $error("replay did not force not-ready");

    AST_EMPTY_NO_READ: assert property (@(posedge rd_clk) disable iff (!nrst) // (R25)
        !rclr && empty_now && !replay_request |=> rbin_q == $past(rbin_q))
        else $error("read pointer moved while empty");

    AST_OE_FOLLOWS: assert property (@(posedge rd_clk) disable iff (!nrst) // (R12)
        $fell(output_drive_enable_n) ##1 !output_drive_enable_n[*2] |-> !data_out_oe_n)
        else $error("output enable did not follow input");

endmodule

// *** dv/dcf_consumer.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Read-side consumer: one read per request, request low stalls
// ----------------------------------------------------------------------------
module dcf_consumer (
    input  wire logic rd_clk,       // Read clock
    input  wire logic nrst,         // Async reset, active low
    input  wire logic req,          // One read wanted; low stalls
    output logic      read_enable   // Read request to the FIFO
);
    always_ff @(negedge rd_clk or negedge nrst) begin
        if (!nrst) begin
            read_enable <= 1'b0;
        end else begin
            read_enable <= req;
        end
    end
endmodule

// *** dv/dcf_fifo_bench.sv ***
`timescale 1ns/1ps

module dcf_fifo_bench;
    import dcf_pkg::*;

    localparam int DEPTH = 512;

    logic      core_clk = 1'b0, rd_clk = 1'b0, nrst = 1'b1;
    logic      full_reset = 1'b0, partial_reset = 1'b0, fall_through_mode = 1'b0;
    logic      offset_access_select = 1'b0, write_enable = 1'b0, serial_load_enable = 1'b0;
    logic      replay_request = 1'b0, output_drive_enable_n = 1'b0, rd_req = 1'b0;
    logic      read_enable, data_out_oe_n;
    logic      full_input_ready_n, empty_output_ready_n, half_full_flag_n;
    logic      almost_full_flag_n, almost_empty_flag_n;
    dcf_word_t data_in = 9'h000;
    dcf_word_t data_out;
    int        n_fail = 0;
    int        tests_run = 0;

    always #2.5 core_clk = ~core_clk;

    // Read clock offset in phase from the write clock
    initial begin
        #1.7;
        forever #24 rd_clk = ~rd_clk;
    end

    dcf_fifo #(.DEPTH(DEPTH)) dut (
        .core_clk(core_clk), .nrst(nrst), .rd_clk(rd_clk), .full_reset(full_reset),
        .partial_reset(partial_reset), .fall_through_mode(fall_through_mode),
        .offset_access_select(offset_access_select), .write_enable(write_enable),
        .serial_load_enable(serial_load_enable), .data_in(data_in),
        .read_enable(read_enable), .replay_request(replay_request),
        .output_drive_enable_n(output_drive_enable_n),
        .full_input_ready_n(full_input_ready_n), .empty_output_ready_n(empty_output_ready_n),
        .almost_full_flag_n(almost_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
        .half_full_flag_n(half_full_flag_n), .data_out(data_out),
        .data_out_oe_n(data_out_oe_n));

    dcf_consumer reader (.rd_clk(rd_clk), .nrst(nrst), .req(rd_req), .read_enable(read_enable));

    // ------------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------------
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input dcf_word_t got, input dcf_word_t exp);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask

    task automatic rw(input int n);
        repeat (n) @(negedge rd_clk);
    endtask

    task automatic wr(input dcf_word_t d);
        @(negedge core_clk);
        write_enable = 1'b1;
        data_in = d;
        @(negedge core_clk);
        write_enable = 1'b0;
    endtask

    // One read through the consumer, data checked once it has settled
    task automatic rd(input dcf_word_t exp);
        @(posedge rd_clk);
        rd_req <= 1'b1;
        @(posedge rd_clk);
        rd_req <= 1'b0;
        @(negedge rd_clk);
        chk(data_out, exp);
    endtask

    task automatic sel(input logic s);
        @(negedge core_clk);
        offset_access_select = s;
        rw(4);
    endtask

    task automatic freset(input logic ft, input logic s);
        @(negedge core_clk);
        fall_through_mode = ft;
        offset_access_select = s;
        full_reset = 1'b1;
        rw(5);
        @(negedge core_clk);
        full_reset = 1'b0;
        rw(4);
        chk(data_out, 9'h000);
        chkb(empty_output_ready_n, ft);
        chkb(full_input_ready_n, 1'b0);
    endtask

    // Almost-empty walk across a programmed empty offset of 5
    task automatic ae_walk;
        for (int i = 1; i <= 5; i++) begin
            wr(9'(i));
            if (i >= 4) begin
                rw(8);
                chkb(almost_empty_flag_n, 1'(i == 5));
            end
        end
    endtask

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        logic [29:0] sbits;
        sbits = {15'h0203, 15'h0155};
        @(negedge core_clk);
        nrst = 1'b0;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        freset(1'b0, 1'b0);
        wr(9'h1A5);
        wr(9'h05A);
        wr(9'h100);
        rw(6);
        chkb(empty_output_ready_n, 1'b1);
        rd(9'h1A5);
        rd(9'h05A);
        rd(9'h100);
        rw(1);
        chkb(empty_output_ready_n, 1'b0);
        rd(9'h100);
        @(negedge rd_clk);
        replay_request = 1'b1;
        @(negedge rd_clk);
        replay_request = 1'b0;
        chkb(empty_output_ready_n, 1'b0);
        rw(4);
        chkb(empty_output_ready_n, 1'b1);
        rd(9'h1A5);
        rd(9'h05A);
        rd(9'h100);
        @(negedge rd_clk);
        output_drive_enable_n = 1'b1;
        rw(3);
        chkb(data_out_oe_n, 1'b1);
        output_drive_enable_n = 1'b0;
        rw(3);
        chkb(data_out_oe_n, 1'b0);
        $display("test basic, replay and output enable done");

        for (int i = 1; i <= DEPTH; i++) begin
            wr(9'(i - 1));
            if (i == 126 || i == 127) begin
                rw(8);
                chkb(almost_empty_flag_n, 1'(i == 127));
            end
            if (i == 256 || i == 257) chkb(half_full_flag_n, 1'(i == 256));
            if (i == 385 || i == 386) chkb(almost_full_flag_n, 1'(i == 385));
            if (i == 511 || i == 512) chkb(full_input_ready_n, 1'(i == 512));
        end
        wr(9'h1AA);
        chkb(full_input_ready_n, 1'b1);
        rw(6);
        for (int k = 0; k < DEPTH; k++) rd(9'(k));
        rd(9'h1FF);
        chkb(almost_empty_flag_n, 1'b0);
        chkb(full_input_ready_n, 1'b0);
        $display("test fill and drain done");

        sel(1'b1);
        wr(9'h005);
        wr(9'h000);
        wr(9'h00A);
        wr(9'h000);
        rw(10);
        rd(9'h005);
        rd(9'h000);
        rd(9'h00A);
        rd(9'h000);
        sel(1'b0);
        ae_walk();
        @(negedge core_clk);
        partial_reset = 1'b1;
        rw(5);
        @(negedge core_clk);
        partial_reset = 1'b0;
        rw(4);
        chk(data_out, 9'h000);
        chkb(empty_output_ready_n, 1'b0);
        ae_walk();
        rd(9'h001);
        $display("test offsets and partial reset done");

        freset(1'b1, 1'b1);
        for (int b = 0; b < 30; b++) begin
            @(negedge core_clk);
            fall_through_mode = sbits[b];
            serial_load_enable = 1'b1;
        end
        @(negedge core_clk);
        serial_load_enable = 1'b0;
        rw(10);
        rd(9'h155);
        rd(9'h000);
        rd(9'h003);
        rd(9'h001);
        sel(1'b0);
        chkb(empty_output_ready_n, 1'b1);
        wr(9'h0C3);
        rw(6);
        chkb(empty_output_ready_n, 1'b0);
        chk(data_out, 9'h0C3);
        $display("test fall-through and serial load done");
        report_and_stop();
    end

    // Whole run takes about 65 us
    initial begin
        #300us;
        n_fail++;
        $display("ERROR at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule
